// ---- core/sbx_port.v ----
// Function
// - Two independent ports, one instance each.
// - Role chosen by configuration, master or slave.
// - Bit rate at most one eighth clock.
// - Full duplex: one byte each way.
// - Mode 0,0: drive falling, sample rising.
// - Mode 1,0: drive rising, sample falling.
// - Phase 1: drive leading edge, sample trailing.
// - Phase 0 select drops between bytes.
// - Slave framing by select or clock edges.
// - Master write starts transfer and clock.
// - Done flag set at end, cleared by access.
`include "sbx_consts.vh"

module sbx_port #(
  parameter DATA_W = 8
) (
  // Clock and reset.
  input  wire              i_clk,
  input  wire              i_rst_b,
  // Configuration.
  input  wire              i_master,
  input  wire              i_clock_polarity,
  input  wire              i_clock_phase,
  input  wire [7:0]        i_half_period,
  // Transmit write and receive read.
  input  wire              i_tx_valid,
  input  wire [DATA_W-1:0] i_tx_data,
  output wire              o_rx_valid,
  output wire [DATA_W-1:0] o_rx_data,
  input  wire              i_rx_ready,
  // Status.
  input  wire              i_flags_clear,
  output wire              o_transfer_done_flag,
  output wire              o_write_collision,
  output wire              o_read_overrun,
  output wire              o_mode_fault,
  output wire              o_slave_abort,
  output wire              o_busy,
  output wire              o_master_active,
  // Serial pins.
  input  wire              i_sck,
  output wire              o_sck,
  output wire              o_sck_oe,
  input  wire              i_mosi,
  output wire              o_mosi,
  output wire              o_mosi_oe,
  input  wire              i_miso,
  output wire              o_miso,
  output wire              o_miso_oe,
  input  wire              i_ssel_b
);

  // Pin synchronisers; only the second and third stages feed logic.
  reg sck_s1_r;
  reg sck_s2_r;
  reg sck_s3_r;
  reg mosi_s1_r;
  reg mosi_s2_r;
  reg miso_s1_r;
  reg miso_s2_r;
  reg ssel_s1_r;
  reg ssel_s2_r;

  // Engine state.
  reg [1:0]        state_r;
  reg [7:0]        divc_r;
  reg [4:0]        ecnt_r;
  reg [3:0]        bcnt_r;
  reg              mid_r;
  reg [DATA_W-1:0] tx_sh_r;
  reg [DATA_W-1:0] rx_sh_r;
  reg [DATA_W-1:0] txd_r;
  reg              out_r;
  reg              sck_r;
  reg              master_r;
  reg              fault_hold_r;
  reg              sck_oe_r;
  reg              mosi_oe_r;
  reg              miso_oe_r;

  // Status flags.
  reg done_r;
  reg wcol_r;
  reg rovr_r;
  reg modf_r;
  reg abrt_r;
  reg busy_r;

  // Two stages on every pin input, three on the link clock, since they come from another party.
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      sck_s1_r  <= 1'b0;
      sck_s2_r  <= 1'b0;
      sck_s3_r  <= 1'b0;
      mosi_s1_r <= 1'b0;
      mosi_s2_r <= 1'b0;
      miso_s1_r <= 1'b0;
      miso_s2_r <= 1'b0;
      ssel_s1_r <= 1'b1;
      ssel_s2_r <= 1'b1;
    end else begin
      sck_s1_r  <= i_sck;
      sck_s2_r  <= sck_s1_r;
      sck_s3_r  <= sck_s2_r;
      mosi_s1_r <= i_mosi;
      mosi_s2_r <= mosi_s1_r;
      miso_s1_r <= i_miso;
      miso_s2_r <= miso_s1_r;
      ssel_s1_r <= i_ssel_b;
      ssel_s2_r <= ssel_s1_r;
    end
  end

  // The half period is clamped so the link never runs faster than allowed.
  wire [7:0] half = (i_half_period < `SBX_MIN_HALF) ? `SBX_MIN_HALF
                                                     : i_half_period;

  // Master edge ticks; even edge counts are leading edges.
  wire run    = (state_r == `SBX_ST_RUN);
  wire m_tick = run && (divc_r == 8'h00) && (ecnt_r != `SBX_EDGES);
  wire m_lead = m_tick && !ecnt_r[0];
  wire m_trl  = m_tick && ecnt_r[0];
  wire m_end  = run && (divc_r == 8'h00) && (ecnt_r == `SBX_EDGES);

  // Slave edges come from the synchronised link clock.
  wire sel    = !ssel_s2_r;
  wire s_act  = !master_r && sel;
  wire s_edge = s_act && (sck_s2_r != sck_s3_r);
  wire s_lead = s_edge && (sck_s2_r != i_clock_polarity);
  wire s_trl  = s_edge && (sck_s2_r == i_clock_polarity);

  // Phase picks which edge drives and which samples.
  wire lead      = m_lead | s_lead;
  wire trl       = m_trl | s_trl;
  wire sample_ev = i_clock_phase ? trl : lead;
  wire drive_ev  = i_clock_phase ? lead
                                 : (trl && mid_r && bcnt_r != `SBX_BITS);
  wire in_bit    = master_r ? miso_s2_r : mosi_s2_r;

  // Slave completes on its eighth sample; the master one half after its last edge.
  wire s_done  = s_act && sample_ev && (bcnt_r == `SBX_BITS - 4'h1);
  wire done_ev = m_end | s_done;
  wire [DATA_W-1:0] done_byte = s_done ? {rx_sh_r[DATA_W-2:0], in_bit}
                                       : rx_sh_r;

  // Slave select leaving mid-byte loses the byte.
  wire s_abort = !master_r && !sel && mid_r;

  // Another master selecting us while we are master is a mode fault.
  wire fault = master_r && sel;

  // Register accesses from the local side.
  wire busy    = run | mid_r;
  wire wr      = i_tx_valid;
  wire rd      = o_rx_valid & i_rx_ready;
  wire buf_rdy;

  // Receive buffer: a stalled reader can hold two words before overrun.
  sbx_buf #(
    .WIDTH (DATA_W),
    .DEPTH (`SBX_BUF_DEPTH)
  ) u_rx_buf (
    .i_clk       (i_clk),
    .i_rst_b     (i_rst_b),
    .i_in_valid  (done_ev),
    .i_in_data   (done_byte),
    .o_in_ready  (buf_rdy),
    .o_out_valid (o_rx_valid),
    .o_out_data  (o_rx_data),
    .i_out_ready (i_rx_ready)
  );

  // Role register; a fault holds the port as slave until the role drops.
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      master_r     <= 1'b0;
      fault_hold_r <= 1'b0;
    end else begin
      master_r     <= i_master && !fault_hold_r && !fault;
      fault_hold_r <= (fault_hold_r && i_master) || fault;
    end
  end

  // Shift engine shared by both roles, so a role change needs no copy.
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      state_r <= `SBX_ST_IDLE;
      divc_r  <= `SBX_RST_HALF;
      ecnt_r  <= 5'h00;
      bcnt_r  <= 4'h0;
      mid_r   <= 1'b0;
      tx_sh_r <= `SBX_RST_BYTE;
      rx_sh_r <= `SBX_RST_BYTE;
      txd_r   <= `SBX_RST_BYTE;
      out_r   <= 1'b0;
      sck_r   <= 1'b0;
    end else begin
      if (wr && !busy) begin
        txd_r <= i_tx_data;
      end
      case (state_r)
        `SBX_ST_IDLE: begin
          sck_r <= i_clock_polarity;
          if (wr && !busy && master_r) begin
            state_r <= `SBX_ST_RUN;
            divc_r  <= half - 8'h01;
            ecnt_r  <= 5'h00;
            bcnt_r  <= 4'h0;
            mid_r   <= 1'b1;
            out_r   <= i_tx_data[DATA_W-1];
            tx_sh_r <= i_clock_phase ? i_tx_data
                                     : {i_tx_data[DATA_W-2:0], 1'b0};
          end else if (!master_r && !mid_r) begin
            // Idle slave keeps the next byte staged for its first edge.
            bcnt_r  <= 4'h0;
            out_r   <= txd_r[DATA_W-1];
            tx_sh_r <= i_clock_phase ? txd_r
                                     : {txd_r[DATA_W-2:0], 1'b0};
          end
        end
        `SBX_ST_RUN: begin
          if (fault) begin
            state_r <= `SBX_ST_IDLE;
            mid_r   <= 1'b0;
          end else if (divc_r != 8'h00) begin
            divc_r <= divc_r - 8'h01;
          end else if (m_end) begin
            state_r <= `SBX_ST_IDLE;
            mid_r   <= 1'b0;
          end else begin
            divc_r <= half - 8'h01;
            sck_r  <= ~sck_r;
            ecnt_r <= ecnt_r + 5'h01;
          end
        end
        default: begin
          state_r <= `SBX_ST_IDLE;
        end
      endcase
      if (drive_ev) begin
        out_r   <= tx_sh_r[DATA_W-1];
        tx_sh_r <= {tx_sh_r[DATA_W-2:0], 1'b0};
        mid_r   <= 1'b1;
      end
      if (sample_ev) begin
        rx_sh_r <= {rx_sh_r[DATA_W-2:0], in_bit};
        bcnt_r  <= bcnt_r + 4'h1;
        mid_r   <= 1'b1;
      end
      if (s_done) begin
        bcnt_r <= 4'h0;
        mid_r  <= 1'b0;
      end
      if (s_abort) begin
        bcnt_r <= 4'h0;
        mid_r  <= 1'b0;
      end
    end
  end

  // Drivers: a slave only drives its output while selected.
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      sck_oe_r  <= 1'b0;
      mosi_oe_r <= 1'b0;
      miso_oe_r <= 1'b0;
      busy_r    <= 1'b0;
    end else begin
      sck_oe_r  <= master_r && !fault;
      mosi_oe_r <= master_r && !fault;
      miso_oe_r <= !master_r && sel;
      busy_r    <= busy;
    end
  end

  // Sticky flags; a set in the same cycle as a clear wins.
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      done_r <= 1'b0;
      wcol_r <= 1'b0;
      rovr_r <= 1'b0;
      modf_r <= 1'b0;
      abrt_r <= 1'b0;
    end else begin
      done_r <= done_ev || (done_r && !(wr || rd));
      wcol_r <= (wr && busy) || (wcol_r && !i_flags_clear);
      rovr_r <= (done_ev && !buf_rdy) || (rovr_r && !i_flags_clear);
      modf_r <= fault || (modf_r && !i_flags_clear);
      abrt_r <= s_abort || (abrt_r && !i_flags_clear);
    end
  end

  // Each instance keeps all its state locally, so two copies never interact.
  assign o_sck                = sck_r;
  assign o_sck_oe             = sck_oe_r;
  assign o_mosi               = out_r;
  assign o_mosi_oe            = mosi_oe_r;
  assign o_miso               = out_r;
  assign o_miso_oe            = miso_oe_r;
  assign o_transfer_done_flag = done_r;
  assign o_write_collision    = wcol_r;
  assign o_read_overrun       = rovr_r;
  assign o_mode_fault         = modf_r;
  assign o_slave_abort        = abrt_r;
  assign o_busy               = busy_r;
  assign o_master_active      = master_r;

endmodule

// ---- core/sbx_consts.vh ----
`ifndef SBX_CONSTS_VH
`define SBX_CONSTS_VH

// Shortest master half period in clock cycles: one bit takes two halves,
// so four cycles per half keeps the bit rate at one eighth of the clock.
`define SBX_MIN_HALF   8'h04
// Bits per transfer and clock edges per transfer.
`define SBX_BITS       4'h8
`define SBX_EDGES      5'h10
// Master engine states.
`define SBX_ST_IDLE    2'h0
`define SBX_ST_RUN     2'h1
// Reset values.
`define SBX_RST_BYTE   8'h00
`define SBX_RST_HALF   8'h00
// Receive buffer depth.
`define SBX_BUF_DEPTH  32'h2

`endif

// ---- core/sbx_buf.v ----
// Small shift buffer: entry 0 is the head, so the outputs come from flops.
module sbx_buf #(
  parameter WIDTH = 8,
  parameter DEPTH = 2
) (
  // Clock and reset.
  input  wire             i_clk,
  input  wire             i_rst_b,
  // Filling side.
  input  wire             i_in_valid,
  input  wire [WIDTH-1:0] i_in_data,
  output wire             o_in_ready,
  // Draining side.
  output wire             o_out_valid,
  output wire [WIDTH-1:0] o_out_data,
  input  wire             i_out_ready
);

  reg [DEPTH-1:0]       vld_r;
  reg [DEPTH*WIDTH-1:0] mem_r;
  reg [DEPTH-1:0]       vld_nxt;
  reg [DEPTH*WIDTH-1:0] mem_nxt;
  reg                   placed;
  integer               i;

  wire pop  = vld_r[0] & i_out_ready;
  wire push = i_in_valid & ~vld_r[DEPTH-1];

  // Pop shifts every entry toward the head, then a push fills the first gap.
  always @* begin
    placed  = 1'b0;
    vld_nxt = vld_r;
    mem_nxt = mem_r;
    if (pop) begin
      vld_nxt = {1'b0, vld_r[DEPTH-1:1]};
      mem_nxt = {{WIDTH{1'b0}}, mem_r[DEPTH*WIDTH-1:WIDTH]};
    end
    for (i = 0; i < DEPTH; i = i + 1) begin
      if (push && !placed && !vld_nxt[i]) begin
        vld_nxt[i]                 = 1'b1;
        mem_nxt[i*WIDTH +: WIDTH]  = i_in_data;
        placed                     = 1'b1;
      end
    end
  end

  // Storage flops; the data is cleared too, though the valid bits alone guard it.
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      vld_r <= {DEPTH{1'b0}};
      mem_r <= {(DEPTH*WIDTH){1'b0}};
    end else begin
      vld_r <= vld_nxt;
      mem_r <= mem_nxt;
    end
  end

  // Full is honest: the last slot taken means no room for another word.
  assign o_in_ready  = ~vld_r[DEPTH-1];
  assign o_out_valid = vld_r[0];
  assign o_out_data  = mem_r[WIDTH-1:0];

endmodule

// ---- verif/sbx_port_checker.sv ----
module sbx_port_checker (
  // Clock, reset and requests.
  input wire logic       i_clk,
  input wire logic       i_rst_b,
  input wire logic       i_tx_valid,
  input wire logic       i_rx_ready,
  input wire logic       i_clock_polarity,
  // Observed outputs.
  input wire logic       o_rx_valid,
  input wire logic [7:0] o_rx_data,
  input wire logic       o_transfer_done_flag,
  input wire logic       o_write_collision,
  input wire logic       o_mode_fault,
  input wire logic       o_busy,
  input wire logic       o_master_active,
  input wire logic       o_sck,
  input wire logic       o_sck_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // An idle master parks its clock at the polarity level.
  chk_sck_idle_level: assert property (o_master_active && $past(o_master_active)
    && !o_busy && $past(!o_busy) && $stable(i_clock_polarity) |-> o_sck == i_clock_polarity)
    else $error("clock not at idle level");
  // Four cycles a half keeps the bit rate at one eighth of the clock.
  chk_sck_half_min: assert property (o_sck_oe && $changed(o_sck) |=> $stable(o_sck)[*3])
    else $error("clock half period too short");
  chk_write_starts: assert property (i_tx_valid && o_master_active && !o_busy
    |-> ##[1:2] o_busy ##[1:8] o_sck != i_clock_polarity) else $error("write did not start");
  chk_write_refused: assert property (i_tx_valid && o_busy ##1 o_busy |-> o_write_collision)
    else $error("busy write not flagged");
  chk_done_pop: assert property (o_transfer_done_flag && o_rx_valid && i_rx_ready && !o_busy
    |=> !o_transfer_done_flag) else $error("pop left done flag set");
  chk_done_data: assert property ($rose(o_transfer_done_flag) |-> o_rx_valid)
    else $error("done without received byte");
  chk_busy_done: assert property ($fell(o_busy) && o_master_active |-> o_transfer_done_flag)
    else $error("master finished without done flag");
  // A fault must hand the clock line back at once and demote the port.
  chk_fault_release: assert property ($rose(o_mode_fault)
    |-> ##[0:1] (!o_sck_oe && !o_master_active)) else $error("fault kept drivers on");
  chk_rx_hold: assert property (o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_data))
    else $error("unread byte changed");
  cov_done: cover property ($rose(o_transfer_done_flag));
  cov_collision: cover property ($rose(o_write_collision));
  cov_fault: cover property ($rose(o_mode_fault));
endmodule

bind sbx_port sbx_port_checker chk_u (.i_clk, .i_rst_b, .i_tx_valid, .i_rx_ready,
  .i_clock_polarity, .o_rx_valid, .o_rx_data, .o_transfer_done_flag, .o_write_collision,
  .o_mode_fault, .o_busy, .o_master_active, .o_sck, .o_sck_oe);

// ---- verif/sbx_slave_model.sv ----
module sbx_slave_model (
  // Link pins.
  input  wire logic       i_sck,
  input  wire logic       i_mosi,
  input  wire logic       i_ssel_b,
  output logic            o_miso,
  // Mode and data.
  input  wire logic       i_clock_polarity,
  input  wire logic       i_clock_phase,
  input  wire logic [7:0] i_tx_byte,
  output logic [7:0]      o_rx_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  int bits = 0;
  initial o_miso = 1'b0;
  initial o_rx_byte = 8'h00;
  // Selection restarts the count; phase 0 needs the first bit before any edge.
  always @(negedge i_ssel_b) begin
    bits = 0;
    if (!i_clock_phase) o_miso = i_tx_byte[7];
  end
  // Released line flips so a stale bit is never mistaken for data.
  always @(posedge i_ssel_b) o_miso = ~o_miso;
  // Only a selected slave answers; sample on rising edges when polarity equals phase.
  always @(i_sck) begin
    if (!i_ssel_b) begin
      if (i_sck == (i_clock_polarity == i_clock_phase)) begin
        o_rx_byte = {o_rx_byte[6:0], i_mosi};
        bits = bits + 1;
      end else if (bits < 8) begin
        o_miso = i_tx_byte[7 - bits];
      end
    end
  end
endmodule

// ---- verif/tb_sbx_port.sv ----
module tb_sbx_port;
  timeunit 1ns;
  timeprecision 1ns;
  // Bench-driven inputs, far master lines and partner control.
  logic       i_clk = 1'b0;
  logic       i_rst_b = 1'b0;
  logic       i_master = 1'b1;
  logic       i_clock_polarity = 1'b0;
  logic       i_clock_phase = 1'b0;
  logic       i_tx_valid = 1'b0;
  logic       i_rx_ready = 1'b0;
  logic       i_flags_clear = 1'b0;
  logic [7:0] i_tx_data = 8'h00;
  logic       m_sck = 1'b0;
  logic       m_mosi = 1'b0;
  logic       m_ssel_b = 1'b1;
  logic       p_ssel_b = 1'b1;
  logic [7:0] p_tx = 8'h00;
  int         num_errors = 0;
  int         comparisons = 0;
  wire        o_rx_valid, o_transfer_done_flag, o_write_collision, o_read_overrun, o_mode_fault;
  wire        o_slave_abort, o_busy, o_master_active, o_sck, o_sck_oe, o_mosi, o_mosi_oe;
  wire        o_miso, o_miso_oe, p_miso;
  wire [7:0]  o_rx_data, p_rx;
  // Each shared line carries whichever party has its driver enabled.
  wire        sck = o_sck_oe ? o_sck : m_sck;
  wire        mosi = o_mosi_oe ? o_mosi : m_mosi;
  wire        miso = o_miso_oe ? o_miso : p_miso;

  sbx_port dut_u (.i_clk, .i_rst_b, .i_master, .i_clock_polarity, .i_clock_phase,
    .i_half_period(8'h02), .i_tx_valid, .i_tx_data, .o_rx_valid, .o_rx_data, .i_rx_ready,
    .i_flags_clear, .o_transfer_done_flag, .o_write_collision, .o_read_overrun, .o_mode_fault,
    .o_slave_abort, .o_busy, .o_master_active, .i_sck(sck), .o_sck, .o_sck_oe, .i_mosi(mosi),
    .o_mosi, .o_mosi_oe, .i_miso(miso), .o_miso, .o_miso_oe, .i_ssel_b(m_ssel_b));
  sbx_slave_model far_u (.i_sck(sck), .i_mosi(mosi), .i_ssel_b(p_ssel_b), .o_miso(p_miso),
    .i_clock_polarity, .i_clock_phase, .i_tx_byte(p_tx), .o_rx_byte(p_rx));

  always #50 i_clk = ~i_clk;

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Inputs set after a cyc change one nanosecond after the rising edge.
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic setup(input logic mst, input int m);
    i_master = mst;
    i_clock_polarity = m[1];
    i_clock_phase = m[0];
    m_sck = m[1];
    i_rst_b = 1'b0;
    cyc(10);
    i_rst_b = 1'b1;
    cyc(4);
  endtask
  task automatic wr(input logic [7:0] d);
    i_tx_data = d;
    i_tx_valid = 1'b1;
    cyc(1);
    i_tx_valid = 1'b0;
  endtask
  // A pop lets one edge pass after it, so two pops never reassign ready at once.
  task automatic pop(input logic [7:0] exp);
    chk("rx valid", 8'(o_rx_valid), 8'h01);
    chk("rx byte", o_rx_data, exp);
    i_rx_ready = 1'b1;
    cyc(1);
    i_rx_ready = 1'b0;
    cyc(1);
  endtask
  task automatic wait_done(output int k);
    k = 0;
    while (o_transfer_done_flag !== 1'b1 && k < 400) begin
      cyc(1);
      k++;
    end
    chk("done flag", 8'(o_transfer_done_flag), 8'h01);
  endtask
  // Far master at 800 ns a bit; its phase is offset from the core clock on purpose.
  task automatic frame(input logic [7:0] tx, input int nbits, output logic [7:0] got);
    got = 8'h00;
    @(posedge i_clk);
    #37;
    m_ssel_b = 1'b0;
    m_mosi = tx[7];
    #400;
    for (int b = 0; b < nbits; b++) begin
      if (i_clock_phase) m_mosi = tx[7 - b];
      if (!i_clock_phase) got = {got[6:0], miso};
      m_sck = ~m_sck;
      #400;
      if (i_clock_phase) got = {got[6:0], miso};
      else if (b < 7) m_mosi = tx[6 - b];
      m_sck = ~m_sck;
      #400;
    end
    m_ssel_b = 1'b1;
    m_mosi = ~m_mosi;
    cyc(6);
  endtask

  task automatic t_master(input int m);
    int k;
    logic [7:0] tx;
    tx = 8'ha5 ^ 8'(m);
    p_tx = 8'h3c + 8'(m);
    setup(1'b1, m);
    chk("idle clock", 8'(sck), 8'(m[1]));
    p_ssel_b = 1'b0;
    wr(tx);
    cyc(1);
    wr(~tx);
    wait_done(k);
    chk("bit pacing", 8'(k > 50), 8'h01);
    chk("collision", 8'(o_write_collision), 8'h01);
    chk("far byte", p_rx, tx);
    cyc(3);
    chk("idle clock", 8'(sck), 8'(m[1]));
    pop(p_tx);
    chk("done cleared", 8'(o_transfer_done_flag), 8'h00);
    p_ssel_b = 1'b1;
    $display("master test mode %0d finished", m);
  endtask
  task automatic t_slave(input int m);
    int k;
    logic [7:0] got;
    setup(1'b0, m);
    wr(8'hc3 ^ 8'(m));
    frame(8'h96 - 8'(m), 8, got);
    wait_done(k);
    chk("slave out", got, 8'hc3 ^ 8'(m));
    chk("slave released", 8'(o_miso_oe), 8'h00);
    pop(8'h96 - 8'(m));
    $display("slave test mode %0d finished", m);
  endtask
  // Fill the two-entry buffer past full, drain it, then cut a byte short.
  task automatic t_stream();
    logic [7:0] got;
    setup(1'b0, 0);
    for (int n = 1; n <= 3; n++) frame(8'(n * 17), 8, got);
    chk("overrun", 8'(o_read_overrun), 8'h01);
    pop(8'h11);
    pop(8'h22);
    chk("buffer empty", 8'(o_rx_valid), 8'h00);
    frame(8'h5a, 4, got);
    chk("abort", 8'(o_slave_abort), 8'h01);
    $display("stream test finished");
  endtask
  task automatic t_fault();
    setup(1'b1, 0);
    m_ssel_b = 1'b0;
    cyc(6);
    chk("mode fault", 8'(o_mode_fault), 8'h01);
    chk("clock released", 8'(o_sck_oe), 8'h00);
    chk("data released", 8'(o_mosi_oe), 8'h00);
    m_ssel_b = 1'b1;
    i_master = 1'b0;
    i_flags_clear = 1'b1;
    cyc(1);
    i_flags_clear = 1'b0;
    chk("fault cleared", 8'(o_mode_fault), 8'h00);
    $display("fault test finished");
  endtask
  task automatic end_of_test();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    for (int m = 0; m < 4; m++) t_master(m);
    for (int m = 0; m < 4; m++) t_slave(m);
    t_stream();
    t_fault();
    end_of_test();
  end
  // Cut a hang short far beyond the expected run length.
  initial begin
    #2000000;
    num_errors++;
    end_of_test();
  end
endmodule
